// ==== verilog/cioxm_params.svh ====
// cioxm_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by the package and the top module by bare name
`ifndef CIOXM_PARAMS_SVH
`define CIOXM_PARAMS_SVH

// clock and link timing
`define CIOXM_CLK_MHZ       25
`define CIOXM_BUS_FAST_MHZ  10
`define CIOXM_BUS_SLOW_MHZ  5
// fast half period, rounded up so the link never runs above its rate
`define CIOXM_HALF_FAST     ((`CIOXM_CLK_MHZ + 2 * `CIOXM_BUS_FAST_MHZ - 1) / (2 * `CIOXM_BUS_FAST_MHZ))
// slow rate is half the fast rate
`define CIOXM_HALF_SLOW     (`CIOXM_HALF_FAST * `CIOXM_BUS_FAST_MHZ / `CIOXM_BUS_SLOW_MHZ)
`define CIOXM_MSG_NS        42000
`define CIOXM_FRAME_BITS    (`CIOXM_MSG_NS * `CIOXM_BUS_FAST_MHZ / 1000)
`define CIOXM_TASK_US       1000
`define CIOXM_TASK_CYC      (`CIOXM_TASK_US * `CIOXM_CLK_MHZ)

// frame layout
`define CIOXM_NSLOT         7
`define CIOXM_SLOT_BITS     32
`define CIOXM_MARK_BITS     8
`define CIOXM_MARK_DATA     8'ha5
`define CIOXM_MARK_ID       8'h3c
`define CIOXM_ID_DIG        2'h1
`define CIOXM_ID_ANA        2'h2

// register word addresses
`define CIOXM_A_CTRL        8'h00
`define CIOXM_A_CFG         8'h01
`define CIOXM_A_STAT        8'h02
`define CIOXM_A_BASE        8'h03
`define CIOXM_A_DOUT        8'h08
`define CIOXM_A_DIN         8'h10
`define CIOXM_A_ACNT        8'h18
`define CIOXM_A_AOUT        8'h20
`define CIOXM_A_AIN         8'h40
`define CIOXM_A_AIN_END     8'hb0

// control fields
`define CIOXM_CTRL_RUN      0
`define CIOXM_CTRL_FAST     1
`define CIOXM_CTRL_DIV_LO   4
`define CIOXM_CFG_MASK_LO   8
`define CIOXM_BASE_W        24

`endif

// ==== verilog/cioxm_pkg.sv ====
// cioxm_pkg: types shared by the cyclic extension bus master
// assumes: cioxm_params.svh on the include path
package cioxm_pkg;
  `include "cioxm_params.svh"
  typedef enum logic [1:0] {CIOXM_IDLE, CIOXM_CHECK, CIOXM_RUN, CIOXM_HALT} cioxm_state_e;
  typedef logic [7:0]  cioxm_addr_t;   // register word address
  typedef logic [31:0] cioxm_word_t;   // register data word
endpackage

// ==== verilog/cioxm_master.sv ====
// cioxm_master: master end of a cyclic serial ring bus to up to seven I/O extension slaves
// assumes: 25 MHz clk, plain register port, bus_din and output_permit_lamp from outside the clock domain
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "cioxm_params.svh"

module cioxm_master #(
  parameter int BASE_CYCLES = `CIOXM_TASK_CYC,  // reset value of the task interval in clocks
  parameter int NAOUT       = 4,                // analog outputs per slave
  parameter int NAIN        = 16                // analog inputs per slave
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire cioxm_pkg::cioxm_addr_t addr,
  input  wire cioxm_pkg::cioxm_word_t wr_data,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output cioxm_pkg::cioxm_word_t   rd_data,
  input  wire logic                output_permit_lamp,
  output logic                     link_active_lamp,
  output logic                     bus_clk,
  output logic                     bus_frame,
  output logic                     bus_dout,
  input  wire logic                bus_din
);
  import cioxm_pkg::*;

  localparam int NS  = `CIOXM_NSLOT;
  localparam int SB  = `CIOXM_SLOT_BITS;
  localparam int MB  = `CIOXM_MARK_BITS;
  localparam int FB  = `CIOXM_FRAME_BITS;
  localparam logic [3:0] HF = 4'(`CIOXM_HALF_FAST);
  localparam logic [3:0] HS = 4'(`CIOXM_HALF_SLOW);
  localparam logic [7:0] MK_ID  = `CIOXM_MARK_ID;    // marker of the arrangement check frame
  localparam logic [7:0] MK_DAT = `CIOXM_MARK_DATA;  // marker of a data frame

  // divisor code to tick count
  function automatic logic [4:0] div_of(input logic [2:0] code);
    unique case (code)
      3'h0:    div_of = 5'h01;
      3'h1:    div_of = 5'h02;
      3'h2:    div_of = 5'h03;
      3'h3:    div_of = 5'h05;
      3'h4:    div_of = 5'h0a;
      3'h5:    div_of = 5'h0f;
      3'h6:    div_of = 5'h14;
      default: div_of = 5'h01;
    endcase
  endfunction

  // next channel in an ascending wrapping rotation over count used channels
  function automatic logic [3:0] rot(input logic [3:0] ch, input logic [3:0] cnt);
    rot = (cnt == 4'h0 || ch + 4'h1 >= cnt) ? 4'h0 : ch + 4'h1;
  endfunction

  // software registers
  logic                    run_reg;                // application running
  logic                    fast_reg;               // fast rate requested
  logic [2:0]              div_code_reg;           // cycle_divisor code
  logic [2:0]              nslave_reg;             // configured slave count
  logic [NS-1:0]           ana_mask_reg;           // slot is analog
  logic [`CIOXM_BASE_W-1:0] base_reg;              // task interval in clocks
  logic [31:0]             dout_reg [NS];          // digital output words
  logic [31:0]             din_reg  [NS];          // digital input words
  logic [3:0]              ain_cnt_reg  [NS];      // used analog inputs
  logic [3:0]              aout_cnt_reg [NS];      // used analog outputs
  logic [15:0]             aout_reg [NS][NAOUT];   // analog output values
  logic [15:0]             ain_reg  [NS][NAIN];    // analog input values
  logic                    cfg_err_reg;            // arrangement mismatch
  logic                    com_err_reg;            // ring echo lost
  cioxm_word_t             rd_data_reg;            // read answer

  // state
  cioxm_state_e            state_reg;
  logic [3:0]              ich_reg [NS];           // current analog input channel
  logic [3:0]              och_reg [NS];           // current analog output channel

  // pacing
  logic [`CIOXM_BASE_W-1:0] base_cnt_reg;
  logic [4:0]              tick_cnt_reg;
  logic                    start_reg;              // one-cycle frame request

  // frame engine
  logic                    busy_reg;
  logic                    id_frame_reg;           // frame is the arrangement check
  logic                    ffast_reg;              // rate of the running frame
  logic [8:0]              bit_cnt_reg;
  logic [3:0]              ph_cnt_reg;
  logic                    done_reg;               // one-cycle frame end
  logic [31:0]             rx_reg [NS];            // slot input shift words
  logic [7:0]              echo_reg;               // marker echoed round the ring
  logic                    bus_clk_reg, bus_frame_reg, bus_dout_reg, lamp_reg;

  // synchronisers
  logic                    din_m_reg, din_s_reg, perm_m_reg, perm_s_reg;

  logic                    do_wr;
  logic [3:0]              half;
  logic                    tx_bit;
  logic [8:0]              rx_lim;

  assign do_wr = wr_en;
  // any analog slave forces the slow rate
  assign half  = ffast_reg ? HF : HS;
  assign rx_lim = 9'(nslave_reg) * 9'(SB);

  // two-flop synchronisers for the pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      din_m_reg  <= 1'b0;
      din_s_reg  <= 1'b0;
      perm_m_reg <= 1'b0;
      perm_s_reg <= 1'b0;
    end else begin
      din_m_reg  <= bus_din;
      din_s_reg  <= din_m_reg;
      perm_m_reg <= output_permit_lamp;
      perm_s_reg <= perm_m_reg;
    end
  end

  // control and configuration writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_reg      <= 1'b0;
      fast_reg     <= 1'b0;
      div_code_reg <= 3'h0;
      nslave_reg   <= 3'h0;
      ana_mask_reg <= '0;
      base_reg     <= `CIOXM_BASE_W'(BASE_CYCLES);
    end else if (do_wr) begin
      if (addr == `CIOXM_A_CTRL) begin
        run_reg      <= wr_data[`CIOXM_CTRL_RUN];
        fast_reg     <= wr_data[`CIOXM_CTRL_FAST];
        div_code_reg <= wr_data[`CIOXM_CTRL_DIV_LO +: 3];
      end
      // seven slaves at most
      if (addr == `CIOXM_A_CFG) begin
        nslave_reg   <= (wr_data[2:0] > 3'(NS)) ? 3'(NS) : wr_data[2:0];
        ana_mask_reg <= wr_data[`CIOXM_CFG_MASK_LO +: NS];
      end
      if (addr == `CIOXM_A_BASE)
        base_reg <= wr_data[`CIOXM_BASE_W-1:0];
    end
  end

  // output data and analog channel counts
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NS; k++) begin
        dout_reg[k]     <= '0;
        ain_cnt_reg[k]  <= 4'h0;
        aout_cnt_reg[k] <= 4'h0;
        for (int c = 0; c < NAOUT; c++) aout_reg[k][c] <= 16'h0000;
      end
    end else if (do_wr) begin
      for (int k = 0; k < NS; k++) begin
        if (addr == `CIOXM_A_DOUT + 8'(k)) dout_reg[k] <= wr_data;
        if (addr == `CIOXM_A_ACNT + 8'(k)) begin
          ain_cnt_reg[k]  <= (wr_data[4:0] > 5'(NAIN)) ? 4'(NAIN - 1) : wr_data[3:0];
          aout_cnt_reg[k] <= (wr_data[10:8] > 3'(NAOUT)) ? 4'(NAOUT) : {1'b0, wr_data[10:8]};
        end
        for (int c = 0; c < NAOUT; c++)
          if (addr == `CIOXM_A_AOUT + 8'(k * NAOUT + c)) aout_reg[k][c] <= wr_data[15:0];
      end
    end
  end

  // register reads, answer in the following cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_reg <= '0;
    end else if (rd_en) begin
      rd_data_reg <= '0;
      if (addr == `CIOXM_A_CTRL)
        rd_data_reg <= 32'({div_code_reg, 2'b00, fast_reg, run_reg});
      if (addr == `CIOXM_A_CFG)
        rd_data_reg <= 32'({ana_mask_reg, 5'h00, nslave_reg});
      if (addr == `CIOXM_A_STAT)
        rd_data_reg <= 32'({state_reg, busy_reg, com_err_reg, cfg_err_reg, lamp_reg});
      if (addr == `CIOXM_A_BASE)
        rd_data_reg <= 32'(base_reg);
      for (int k = 0; k < NS; k++) begin
        if (addr == `CIOXM_A_DOUT + 8'(k)) rd_data_reg <= dout_reg[k];
        if (addr == `CIOXM_A_DIN + 8'(k))  rd_data_reg <= din_reg[k];
        if (addr == `CIOXM_A_ACNT + 8'(k)) rd_data_reg <= 32'({aout_cnt_reg[k], 4'h0, ain_cnt_reg[k]});
        for (int c = 0; c < NAOUT; c++)
          if (addr == `CIOXM_A_AOUT + 8'(k * NAOUT + c)) rd_data_reg <= 32'(aout_reg[k][c]);
        for (int c = 0; c < NAIN; c++)
          if (addr == `CIOXM_A_AIN + 8'(k * NAIN + c)) rd_data_reg <= 32'(ain_reg[k][c]);
      end
    end else begin
      rd_data_reg <= '0;
    end
  end

  // task tick and divisor: frame request at the end of every Nth tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      base_cnt_reg <= '0;
      tick_cnt_reg <= 5'h00;
      start_reg    <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (state_reg != CIOXM_RUN) begin
        base_cnt_reg <= '0;
        tick_cnt_reg <= 5'h00;
      end else if (base_cnt_reg + 1'b1 >= base_reg) begin
        base_cnt_reg <= '0;
        if (tick_cnt_reg + 5'h01 >= div_of(div_code_reg)) begin
          tick_cnt_reg <= 5'h00;
          start_reg    <= 1'b1;
        end else begin
          tick_cnt_reg <= tick_cnt_reg + 5'h01;
        end
      end else begin
        base_cnt_reg <= base_cnt_reg + 1'b1;
      end
    end
  end

  // outgoing bit: marker, then every slot in a data frame (none in a check frame), then idle fill to a fixed length
  always_comb begin
    logic [8:0]  idx;
    logic [2:0]  sl;
    logic [31:0] w;
    idx    = bit_cnt_reg - 9'(MB);
    sl     = idx[7:5];
    w      = '0;
    tx_bit = 1'b0;
    if (bit_cnt_reg < 9'(MB)) begin
      tx_bit = id_frame_reg ? MK_ID[3'(MB - 1) - bit_cnt_reg[2:0]] : MK_DAT[3'(MB - 1) - bit_cnt_reg[2:0]];
    end else if (idx < 9'(NS * SB) && !id_frame_reg) begin
      // slot content follows the slot's module type
      if (ana_mask_reg[sl])
        w = {och_reg[sl], ich_reg[sl], 8'h00, aout_reg[sl][och_reg[sl][1:0]]};
      else
        w = dout_reg[sl];
      tx_bit = w[5'(SB - 1) - idx[4:0]];
    end
  end

  // frame engine: shifts one fixed-length frame through the ring
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg      <= 1'b0;
      id_frame_reg  <= 1'b0;
      ffast_reg     <= 1'b0;
      bit_cnt_reg   <= '0;
      ph_cnt_reg    <= 4'h0;
      done_reg      <= 1'b0;
      bus_clk_reg   <= 1'b1;
      bus_frame_reg <= 1'b0;
      bus_dout_reg  <= 1'b0;
      echo_reg      <= 8'h00;
      for (int k = 0; k < NS; k++) rx_reg[k] <= '0;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg) begin
        bus_clk_reg   <= 1'b1;
        bus_frame_reg <= 1'b0;
        // forget a finished check outside checking, else a later restart never checks again
        if (state_reg != CIOXM_CHECK)
          id_frame_reg <= 1'b0;
        // a request while a frame runs is dropped
        if (start_reg || (state_reg == CIOXM_CHECK && !id_frame_reg)) begin
          busy_reg      <= 1'b1;
          id_frame_reg  <= (state_reg == CIOXM_CHECK);
          ffast_reg     <= fast_reg && (ana_mask_reg == '0);
          bit_cnt_reg   <= '0;
          ph_cnt_reg    <= 4'h0;
        end
      end else if (state_reg == CIOXM_HALT || state_reg == CIOXM_IDLE) begin
        // termination cuts the frame short
        busy_reg      <= 1'b0;
        id_frame_reg  <= 1'b0;
        bus_frame_reg <= 1'b0;
        bus_clk_reg   <= 1'b1;
      end else begin
        ph_cnt_reg <= ph_cnt_reg + 4'h1;
        if (ph_cnt_reg == 4'h0) begin
          // falling edge: present the next bit
          bus_frame_reg <= 1'b1;
          bus_clk_reg   <= 1'b0;
          bus_dout_reg  <= tx_bit;
        end
        if (ph_cnt_reg == half)
          bus_clk_reg <= 1'b1;
        if (ph_cnt_reg == half + half - 4'h1) begin
          // end of bit: sample what came back round the ring
          ph_cnt_reg <= 4'h0;
          if (bit_cnt_reg < rx_lim)
            rx_reg[bit_cnt_reg[7:5]] <= {rx_reg[bit_cnt_reg[7:5]][30:0], din_s_reg};
          else if (bit_cnt_reg < rx_lim + 9'(MB))
            echo_reg <= {echo_reg[6:0], din_s_reg};
          if (bit_cnt_reg == 9'(FB - 1)) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 9'h001;
          end
        end
      end
    end
  end

  // sequencer: check, run, halt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= CIOXM_IDLE;
      cfg_err_reg <= 1'b0;
      com_err_reg <= 1'b0;
      lamp_reg    <= 1'b0;
    end else begin
      unique case (state_reg)
        CIOXM_IDLE: begin
          lamp_reg <= 1'b0;
          if (run_reg && perm_s_reg) begin
            cfg_err_reg <= 1'b0;
            com_err_reg <= 1'b0;
            state_reg   <= CIOXM_CHECK;
          end
        end
        CIOXM_CHECK: begin
          if (!run_reg || !perm_s_reg) begin
            state_reg <= CIOXM_HALT;
          end else if (done_reg) begin
            // attached slaves must match the configured arrangement
            logic bad;
            bad = (echo_reg != `CIOXM_MARK_ID);
            for (int k = 0; k < NS; k++)
              if (k < int'(nslave_reg) &&
                  rx_reg[k][1:0] != (ana_mask_reg[k] ? `CIOXM_ID_ANA : `CIOXM_ID_DIG))
                bad = 1'b1;
            cfg_err_reg <= bad;
            state_reg   <= bad ? CIOXM_HALT : CIOXM_RUN;
          end
        end
        CIOXM_RUN: begin
          if (!run_reg || !perm_s_reg) begin
            lamp_reg  <= 1'b0;
            state_reg <= CIOXM_HALT;
          end else if (done_reg) begin
            if (echo_reg != `CIOXM_MARK_DATA) begin
              com_err_reg <= 1'b1;
              lamp_reg    <= 1'b0;
              state_reg   <= CIOXM_HALT;
            end else begin
              lamp_reg <= 1'b1;
            end
          end
        end
        CIOXM_HALT: begin
          lamp_reg <= 1'b0;
          // restart only after the application stops
          if (!run_reg)
            state_reg <= CIOXM_IDLE;
        end
      endcase
    end
  end

  // input latch and analog rotation, only on a good data frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NS; k++) begin
        din_reg[k] <= '0;
        ich_reg[k] <= 4'h0;
        och_reg[k] <= 4'h0;
        for (int c = 0; c < NAIN; c++) ain_reg[k][c] <= 16'h0000;
      end
    end else if (state_reg != CIOXM_RUN) begin
      for (int k = 0; k < NS; k++) begin
        ich_reg[k] <= 4'h0;
        och_reg[k] <= 4'h0;
      end
    end else if (done_reg && echo_reg == `CIOXM_MARK_DATA) begin
      for (int k = 0; k < NS; k++) begin
        if (k < int'(nslave_reg)) begin
          if (ana_mask_reg[k]) begin
            ain_reg[k][ich_reg[k]] <= rx_reg[k][15:0];
            ich_reg[k] <= rot(ich_reg[k], ain_cnt_reg[k]);
            och_reg[k] <= rot(och_reg[k], aout_cnt_reg[k]);
          end else begin
            din_reg[k] <= rx_reg[k];
          end
        end
      end
    end
  end

  // outputs straight from flip-flops
  assign rd_data          = rd_data_reg;
  assign link_active_lamp = lamp_reg;
  assign bus_clk          = bus_clk_reg;
  assign bus_frame        = bus_frame_reg;
  assign bus_dout         = bus_dout_reg;

endmodule

// ==== tb/cioxm_master_properties.sv ====
// cioxm_master_properties: port-level checks of the cyclic extension bus master
// assumes: bound to cioxm_master, one clock domain, async active-low reset
`timescale 1ns/1ps
`include "cioxm_params.svh"

module cioxm_master_checker (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire cioxm_pkg::cioxm_addr_t addr,
  input wire cioxm_pkg::cioxm_word_t wr_data,
  input wire logic                   wr_en,
  input wire logic                   rd_en,
  input wire cioxm_pkg::cioxm_word_t rd_data,
  input wire logic                   output_permit_lamp,
  input wire logic                   link_active_lamp,
  input wire logic                   bus_clk,
  input wire logic                   bus_frame,
  input wire logic                   bus_dout,
  input wire logic                   bus_din
);
  import cioxm_pkg::*;
  localparam int FAST_LEN = `CIOXM_FRAME_BITS * 2 * `CIOXM_HALF_FAST;  // clocks per fast frame
  localparam int SLOW_LEN = `CIOXM_FRAME_BITS * 2 * `CIOXM_HALF_SLOW;  // clocks per slow frame
  logic [12:0] flen_reg;   // clocks the running frame has stood
  logic        abort_reg;  // frame cut short by permit loss or a stop write
  logic        ana_reg;    // an analog slot is configured

  // frame length and abort tracking, cleared between frames
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flen_reg  <= '0;
      abort_reg <= 1'b0;
    end else begin
      flen_reg  <= bus_frame ? flen_reg + 13'h1 : 13'h0;
      abort_reg <= bus_frame & (abort_reg | ~output_permit_lamp | (wr_en & (addr == `CIOXM_A_CTRL) & ~wr_data[0]));
    end
  end

  // follow the analog mask written to the configuration word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ana_reg <= 1'b0;
    else if (wr_en && addr == `CIOXM_A_CFG) ana_reg <= |wr_data[14:8];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  clk_idle_a:
    assert property (!bus_frame |-> bus_clk) else $error("link clock low outside a frame");
  frame_start_a:
    assert property ($rose(bus_frame) |-> !bus_clk) else $error("frame opened without falling clock");
  dout_edge_a:
    assert property (bus_frame && $past(bus_frame) && $changed(bus_dout) |-> $fell(bus_clk))
      else $error("serial data moved off the falling clock");
  half_min_a:
    assert property (bus_frame && $changed(bus_clk) |=> $stable(bus_clk)) else $error("link half period too short");
  frame_len_a:
    assert property ($fell(bus_frame) && !abort_reg |-> flen_reg == FAST_LEN || flen_reg == SLOW_LEN)
      else $error("frame length wrong");
  slow_rate_a:
    assert property ($fell(bus_frame) && ana_reg && !abort_reg |-> flen_reg == SLOW_LEN)
      else $error("analog group not at slow rate");
  lamp_drop_a:
    assert property ($fell(output_permit_lamp) |-> ##[1:8] !link_active_lamp) else $error("lamp stayed on");
  lamp_hold_a:
    assert property ((!output_permit_lamp)[*8] |-> !link_active_lamp) else $error("lamp on without permit");
  frame_abort_a:
    assert property (bus_frame && $fell(output_permit_lamp) |-> ##[1:8] !bus_frame) else $error("frame not stopped");
  lamp_rise_a:
    assert property ($rose(link_active_lamp) |-> !bus_frame) else $error("lamp lit inside a frame");

  good_frame_c: cover property ($fell(bus_frame) && !abort_reg);
  abort_frame_c: cover property (bus_frame && $fell(output_permit_lamp));
  lamp_on_c: cover property ($rose(link_active_lamp));
endmodule

bind cioxm_master cioxm_master_checker chk_u (.clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .output_permit_lamp(output_permit_lamp),
  .link_active_lamp(link_active_lamp), .bus_clk(bus_clk), .bus_frame(bus_frame), .bus_dout(bus_dout), .bus_din(bus_din));

// ==== tb/cioxm_ring_model.sv ====
// cioxm_ring_model: ring of extension slaves behind the master, all slots alike
// assumes: link lines sampled mid-cycle on the falling edge of clk
`timescale 1ns/1ps

module cioxm_ring_model #(
  parameter int SILENT_CYC = 1250000  // silence limit, 50 ms at 25 MHz
) (
  input  wire logic        clk,
  input  wire logic        bus_clk,
  input  wire logic        bus_frame,
  input  wire logic        bus_dout,
  output logic             bus_din,
  input  wire logic [2:0]  nslv,
  input  wire logic [31:0] rx_word,
  input  wire logic        bad_echo,
  output logic [7:0]       tx_mark,
  output logic [31:0]      tx_word,
  output logic             outputs_on
);
  logic [0:419] tx_bits;  // bits seen from the master this frame
  logic         pclk;     // link clock one cycle ago
  logic         pfrm;     // frame line one cycle ago
  int           idx;      // next bit to return
  int           ridx;     // next bit to capture
  int           quiet;    // clocks since the last frame

  initial begin
    {bus_din, pfrm, outputs_on, tx_bits, tx_mark, tx_word} = '0;
    pclk = 1'b1;
    {idx, ridx, quiet} = '0;
  end

  // one process per clock: watchdog, return path, capture
  always @(negedge clk) begin
    if (bus_frame && !pfrm) begin
      {idx, ridx, quiet} = '0;
      outputs_on = 1'b1;
    end else if (quiet >= SILENT_CYC) outputs_on = 1'b0;
    else quiet++;
    // slot words first, then the echo of what the master sent
    if (bus_frame && pclk && !bus_clk) begin
      if (idx < int'(nslv) * 32) bus_din = rx_word[31 - idx % 32];
      else bus_din = tx_bits[idx - int'(nslv) * 32] ^ bad_echo;
      idx++;
    end else if (!bus_frame) bus_din = ~bus_din;
    if (bus_frame && !pclk && bus_clk && ridx < 420) begin
      tx_bits[ridx] = bus_dout;
      ridx++;
    end
    if (!bus_frame && pfrm) begin
      tx_mark = tx_bits[0:7];
      tx_word = tx_bits[8:39];
    end
    pclk = bus_clk;
    pfrm = bus_frame;
  end
endmodule

// ==== tb/cioxm_master_tb_top.sv ====
// cioxm_master_tb_top: register-driven tests of the bus master against a slave ring
// assumes: 25 MHz clock, BASE_CYCLES shortened to 50, checker bound to the master
`timescale 1ns/1ps
`include "cioxm_params.svh"

module cioxm_master_tb_top;
  import cioxm_pkg::*;
  localparam int SLOW_LEN = `CIOXM_FRAME_BITS * 2 * `CIOXM_HALF_SLOW;  // clocks per slow frame
  logic        clk, nrst, wr_en, rd_en, permit, bad_echo, link_active_lamp;
  logic        bus_clk, bus_frame, bus_dout, bus_din, outputs_on;
  cioxm_addr_t addr;
  cioxm_word_t wr_data, rd_data;
  logic [31:0] rx_word, tx_word;
  logic [7:0]  tx_mark;
  int          fails, cmp_count;

  cioxm_master #(.BASE_CYCLES(50)) dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .output_permit_lamp(permit), .link_active_lamp(link_active_lamp),
    .bus_clk(bus_clk), .bus_frame(bus_frame), .bus_dout(bus_dout), .bus_din(bus_din));
  cioxm_ring_model ring_u (.clk(clk), .bus_clk(bus_clk), .bus_frame(bus_frame), .bus_dout(bus_dout),
    .bus_din(bus_din), .nslv(3'h1), .rx_word(rx_word), .bad_echo(bad_echo), .tx_mark(tx_mark),
    .tx_word(tx_word), .outputs_on(outputs_on));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic wr(input cioxm_addr_t a, input cioxm_word_t d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // one read; the answer stands only in the cycle after the strobe
  task automatic rd(input cioxm_addr_t a, output cioxm_word_t d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask

  // read, then compare the masked answer
  task automatic rdc(input cioxm_addr_t a, input cioxm_word_t m, input cioxm_word_t e, input string w);
    cioxm_word_t d;
    rd(a, d);
    chk(w, e, d & m);
  endtask

  // poll the state field until it reaches s; polls themselves count no mismatch
  task automatic wait_state(input logic [1:0] s);
    cioxm_word_t d;
    for (int i = 0; i < 4000; i++) begin
      rd(`CIOXM_A_STAT, d);
      if (d[5:4] === s) break;
    end
    chk("state", 32'(s), 32'(d[5:4]));
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    complete_run();
  end

  initial begin
    longint t0;
    int base [7] = '{1800, 900, 600, 360, 180, 120, 90};
    {nrst, addr, wr_data, wr_en, rd_en, bad_echo, fails, cmp_count} = '0;
    permit = 1'b1;
    rx_word = 32'h5a5ac3c1;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rdc(`CIOXM_A_CTRL, '1, 32'h0, "ctrl reset");
    rdc(`CIOXM_A_BASE, '1, 32'd50, "base reset");
    rdc(8'hff, '1, 32'h0, "unmapped");
    // ring answers digital but an analog slot is configured
    wr(`CIOXM_A_CFG, 32'h101);
    wr(`CIOXM_A_CTRL, 32'h1);
    wait_state(2'h3);
    rdc(`CIOXM_A_STAT, 32'h3, 32'h2, "cfg mismatch");
    wr(`CIOXM_A_CFG, 32'h1);
    wr(`CIOXM_A_DOUT, 32'h12345678);
    // divisor codes 0 to 6, base chosen so each spacing is 1800 clocks
    for (int i = 0; i < 7; i++) begin
      wr(`CIOXM_A_CTRL, 32'h0);
      wait_state(2'h0);
      wr(`CIOXM_A_BASE, 32'(base[i]));
      wr(`CIOXM_A_CTRL, 32'(i << 4) | 32'h3);
      repeat (2) @(posedge bus_frame);
      t0 = $time;
      @(posedge bus_frame);
      chk("spacing", 32'd1800, 32'(($time - t0) / 40));
    end
    @(negedge bus_frame);
    repeat (4) @(posedge clk);
    rdc(`CIOXM_A_DIN, '1, 32'h5a5ac3c1, "slot input");
    chk("marker", 32'ha5, 32'(tx_mark));
    chk("slot output", 32'h12345678, tx_word);
    chk("slave outputs", 32'h1, 32'(outputs_on));
    rdc(`CIOXM_A_STAT, 32'h33, 32'h21, "lamp on");
    // permit lost in mid-frame
    @(posedge bus_frame);
    repeat (100) @(posedge clk);
    permit <= 1'b0;
    repeat (20) @(posedge clk);
    rdc(`CIOXM_A_STAT, 32'h39, 32'h30, "permit stop");
    wr(`CIOXM_A_CTRL, 32'h0);
    permit <= 1'b1;
    wait_state(2'h0);
    // broken echo while running
    wr(`CIOXM_A_CTRL, 32'h63);
    wait_state(2'h2);
    bad_echo <= 1'b1;
    wait_state(2'h3);
    rdc(`CIOXM_A_STAT, 32'h5, 32'h4, "echo error");
    wr(`CIOXM_A_CTRL, 32'h0);
    bad_echo <= 1'b0;
    wait_state(2'h0);
    // analog slot: 2 outputs and 3 inputs in use, fast asked for
    wr(`CIOXM_A_CFG, 32'h101);
    wr(`CIOXM_A_ACNT, 32'h203);
    wr(`CIOXM_A_AOUT, 32'ha000);
    wr(`CIOXM_A_AOUT + 8'h1, 32'ha001);
    wr(`CIOXM_A_BASE, 32'd3500);
    rx_word <= 32'h0000beee;
    wr(`CIOXM_A_CTRL, 32'h3);
    wait_state(2'h2);
    for (int k = 0; k < 6; k++) begin
      @(posedge bus_frame);
      t0 = $time;
      @(negedge bus_frame);
      chk("slow frame", 32'(SLOW_LEN), 32'(($time - t0) / 40));
      repeat (2) @(posedge clk);
      chk("analog slot", {4'(k % 2), 4'(k % 3), 8'h0, 16'ha000 + 16'(k % 2)}, tx_word);
    end
    for (int c = 0; c < 4; c++) begin
      rdc(`CIOXM_A_AIN + 8'(c), '1, (c < 3) ? 32'h0000beee : 32'h0, "analog input");
    end
    complete_run();
  end
endmodule
